// [hdl/bsm_consts.svh]
// Constants of the breakpoint snoop match block
// Function
// R1 - Bus selector 00 watches the instruction bus, 01 the X bus, 10 the Y bus; 11 is illegal.
// R2 - Access-type 00 disables the breakpoint so it never produces an event.
// R3 - Access-type 01 responds only to fetch or read accesses.
// R4 - Access-type 10 responds only to write accesses.
// R5 - Access-type 11 responds to both read and write accesses.
// R6 - Condition 000 disables, 001 matches address alone; 110 and 111 must not be programmed.
// R7 - Condition 010 needs X/Y data equal to the stored data.
// R8 - Condition 011 needs X/Y data different from the stored data.
// R9 - Condition 100 needs X/Y data signed less than the stored data.
// R10 - Condition 101 needs X/Y data signed greater than or equal to the stored data.
// R11 - Config holds triggered flag at 7, bus at 6:5, access at 4:3, condition at 2:0.
// R12 - The triggered flag is set when its breakpoint causes the interrupt.
// R13 - A 16-bit down counter decrements per event; an event at zero fires and captures the fetch address.
// R14 - The snoop enable gates all matching, clears itself on firing; up to eight breakpoints.
// R15 - An event needs bus, access type, address and data condition to match in one cycle.
// R16 - On the instruction bus only the address-only condition can match.
`ifndef BSM_CONSTS_SVH
`define BSM_CONSTS_SVH

// ****************************************
// Widths and counts
// ****************************************
`define BSM_AW 16
`define BSM_DW 16
`define BSM_NBP 8
`define BSM_WB_AW 8

// ****************************************
// Register offsets
// ****************************************
`define BSM_OFS_CTRL 8'h00
`define BSM_OFS_COUNT 8'h04
`define BSM_OFS_BREAK_INSTR_ADDRESS 8'h08
`define BSM_OFS_IRQ_ST 8'h0c
`define BSM_OFS_IRQ_MASK 8'h10
`define BSM_BP_AREA_BIT 7
`define BSM_WORD_CFG 2'h0
`define BSM_WORD_ADDR 2'h1
`define BSM_WORD_DATA 2'h2

// ****************************************
// Field positions
// ****************************************
`define BSM_CFG_TRIG 7
`define BSM_ENA_BIT 0
`define BSM_IRQ_BRK_BIT 0

// ****************************************
// Field codes
// ****************************************
`define BSM_BUS_I 2'h0
`define BSM_BUS_X 2'h1
`define BSM_BUS_Y 2'h2
`define BSM_ACC_OFF 2'h0
`define BSM_ACC_RD 2'h1
`define BSM_ACC_WR 2'h2
`define BSM_ACC_RW 2'h3
`define BSM_COND_OFF 3'h0
`define BSM_COND_ADDR 3'h1
`define BSM_COND_EQ 3'h2
`define BSM_COND_NE 3'h3
`define BSM_COND_LT 3'h4
`define BSM_COND_GE 3'h5

// ****************************************
// Reset values
// ****************************************
`define BSM_RST_COUNT 16'h0000
`define BSM_RST_BREAK_INSTR_ADDRESS 16'h0000
`define BSM_RST_MASK 1'b0

`endif

// [hdl/bsm_pkg.sv]
// Types of the breakpoint snoop match block
`include "bsm_consts.svh"
package bsm_pkg;

    // One snooped bus access in one cycle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [`BSM_AW-1:0] addr;
        logic [`BSM_DW-1:0] data;
    } bsm_bus_t;

    // One breakpoint: configuration, address and data
    typedef struct packed {
        logic trig;
        logic [1:0] bus;
        logic [1:0] acc;
        logic [2:0] cond;
        logic [`BSM_AW-1:0] addr;
        logic [`BSM_DW-1:0] data;
    } bsm_bp_t;

endpackage

// [hdl/bsm_match.sv]
// Match logic of one breakpoint against the three snooped buses
`include "bsm_consts.svh"
module bsm_match (
    // Breakpoint setup
    input wire bsm_pkg::bsm_bp_t bp_i,
    // Snooped buses
    input wire bsm_pkg::bsm_bus_t ibus_i,
    input wire bsm_pkg::bsm_bus_t xbus_i,
    input wire bsm_pkg::bsm_bus_t ybus_i,
    // Result
    output logic hit_o
);
    bsm_pkg::bsm_bus_t sel;
    logic is_ibus;
    logic acc_ok;
    logic addr_ok;
    logic cond_ok;

    always_comb begin
        sel = '0;
        is_ibus = 1'b0;
        unique case (bp_i.bus)
            `BSM_BUS_I: begin // [R1]
                sel.rd = ibus_i.rd;
                sel.addr = ibus_i.addr;
                is_ibus = 1'b1;
            end
            `BSM_BUS_X: sel = xbus_i; // [R1]
            `BSM_BUS_Y: sel = ybus_i; // [R1]
            default: sel = '0;
        endcase
    end

    // Code 00 has neither bit, so it never matches
    assign acc_ok = (bp_i.acc[0] & sel.rd) | (bp_i.acc[1] & sel.wr); // [R2] [R3] [R4] [R5]
    assign addr_ok = sel.addr == bp_i.addr;

    always_comb begin
        cond_ok = 1'b0;
        unique case (bp_i.cond)
            `BSM_COND_ADDR: cond_ok = 1'b1; // [R6]
            `BSM_COND_EQ: cond_ok = sel.data == bp_i.data; // [R7]
            `BSM_COND_NE: cond_ok = sel.data != bp_i.data; // [R8]
            `BSM_COND_LT: cond_ok = $signed(sel.data) < $signed(bp_i.data); // [R9]
            `BSM_COND_GE: cond_ok = $signed(sel.data) >= $signed(bp_i.data); // [R10]
            default: cond_ok = 1'b0; // [R6]
        endcase
        if (is_ibus && bp_i.cond != `BSM_COND_ADDR) begin
            cond_ok = 1'b0; // [R16]
        end
    end

    assign hit_o = acc_ok & addr_ok & cond_ok; // [R15]

endmodule // bsm_match

// [hdl/bsm_top.sv]
// Breakpoint snoop matcher with a Wishbone register file
`include "bsm_consts.svh"
module bsm_top #(
    parameter int NBP = `BSM_NBP
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`BSM_WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Snooped core buses
    input wire bsm_pkg::bsm_bus_t ibus_i,
    input wire bsm_pkg::bsm_bus_t xbus_i,
    input wire bsm_pkg::bsm_bus_t ybus_i,
    // Status
    output logic snoop_enable_o,
    output logic break_o,
    output logic irq_o
);
    // ****************************************
    // Declarations
    // ****************************************
    bsm_pkg::bsm_bp_t bp_reg [NBP];
    logic [NBP-1:0] hit;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [31:0] rd_mux;
    logic ena_reg;
    logic [`BSM_AW-1:0] event_down_count_reg;
    logic [`BSM_AW-1:0] break_instr_address_reg;
    logic irq_st_reg;
    logic irq_mask_reg;
    logic break_reg;
    logic req;
    logic take;
    logic wr_take;
    logic rd_take;
    logic in_bp;
    logic [2:0] bp_idx;
    logic [1:0] bp_word;
    logic snoop_event;
    logic fire;
    logic [7:0] reg_ofs;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Byte lanes of a 16-bit register in the low half of the word
    function automatic logic [15:0] lane16(
        input logic [15:0] old,
        input logic [31:0] d,
        input logic [3:0] s
    );
        lane16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // ****************************************
    // Wishbone decode
    // ****************************************
    assign req = wb_cyc_i & wb_stb_i;
    // Access takes effect at the edge where the master sees ack
    assign take = req & ack_reg;
    assign wr_take = take & wb_we_i;
    assign rd_take = take & ~wb_we_i;
    assign bp_idx = wb_adr_i[6:4];
    assign bp_word = wb_adr_i[3:2];
    assign reg_ofs = {wb_adr_i[7:2], 2'b00};
    assign in_bp = wb_adr_i[`BSM_BP_AREA_BIT] && (int'(bp_idx) < NBP);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    always_comb begin
        rd_mux = '0;
        if (in_bp) begin
            unique case (bp_word)
                `BSM_WORD_CFG: begin // [R11]
                    rd_mux[7:0] = {bp_reg[bp_idx].trig, bp_reg[bp_idx].bus,
                        bp_reg[bp_idx].acc, bp_reg[bp_idx].cond};
                end
                `BSM_WORD_ADDR: rd_mux[`BSM_AW-1:0] = bp_reg[bp_idx].addr;
                `BSM_WORD_DATA: rd_mux[`BSM_DW-1:0] = bp_reg[bp_idx].data;
                default: rd_mux = '0;
            endcase
        end else if (!wb_adr_i[`BSM_BP_AREA_BIT]) begin
            unique case (reg_ofs)
                `BSM_OFS_CTRL: rd_mux[`BSM_ENA_BIT] = ena_reg;
                `BSM_OFS_COUNT: rd_mux[`BSM_AW-1:0] = event_down_count_reg;
                `BSM_OFS_BREAK_INSTR_ADDRESS: rd_mux[`BSM_AW-1:0] = break_instr_address_reg;
                `BSM_OFS_IRQ_ST: rd_mux[`BSM_IRQ_BRK_BIT] = irq_st_reg;
                `BSM_OFS_IRQ_MASK: rd_mux[`BSM_IRQ_BRK_BIT] = irq_mask_reg;
                default: rd_mux = '0;
            endcase
        end
    end

    // Read data is latched with the request so it stays stable under ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= '0;
        end else if (req && !ack_reg) begin
            dat_reg <= rd_mux;
        end
    end

    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;

    // ****************************************
    // Breakpoints
    // ****************************************
    generate
        for (genvar k = 0; k < NBP; k++) begin : g_bp
            logic sel_k;
            assign sel_k = wr_take && in_bp && bp_idx == 3'(k);

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    bp_reg[k] <= '0;
                end else begin
                    if (sel_k && bp_word == `BSM_WORD_CFG && wb_sel_i[0]) begin
                        bp_reg[k].trig <= wb_dat_i[`BSM_CFG_TRIG]; // [R11]
                        bp_reg[k].bus <= wb_dat_i[6:5]; // [R11]
                        bp_reg[k].acc <= wb_dat_i[4:3]; // [R11]
                        bp_reg[k].cond <= wb_dat_i[2:0]; // [R11]
                    end
                    if (sel_k && bp_word == `BSM_WORD_ADDR) begin
                        bp_reg[k].addr <=
                            lane16(bp_reg[k].addr, wb_dat_i, wb_sel_i);
                    end
                    if (sel_k && bp_word == `BSM_WORD_DATA) begin
                        bp_reg[k].data <=
                            lane16(bp_reg[k].data, wb_dat_i, wb_sel_i);
                    end
                    // Set beats a software clear in the same cycle
                    if (fire && hit[k]) begin
                        bp_reg[k].trig <= 1'b1; // [R12]
                    end
                end
            end

            bsm_match u_match (
                .bp_i(bp_reg[k]),
                .ibus_i(ibus_i),
                .xbus_i(xbus_i),
                .ybus_i(ybus_i),
                .hit_o(hit[k])
            );

            access_off_a: assert property ( // [R2]
                bp_reg[k].acc == `BSM_ACC_OFF |-> !hit[k])
                else $error("disabled access type produced a hit");
            cond_off_a: assert property ( // [R6]
                (bp_reg[k].cond == `BSM_COND_OFF || bp_reg[k].cond > 3'h5)
                |-> !hit[k])
                else $error("disabled condition produced a hit");
            ibus_addr_a: assert property ( // [R1]
                hit[k] && bp_reg[k].bus == `BSM_BUS_I |->
                ibus_i.rd && ibus_i.addr == bp_reg[k].addr
                && bp_reg[k].cond == `BSM_COND_ADDR)
                else $error("instruction bus hit without fetch match");
            read_only_a: assert property ( // [R3]
                hit[k] && bp_reg[k].acc == `BSM_ACC_RD
                && bp_reg[k].bus == `BSM_BUS_X |-> xbus_i.rd)
                else $error("read breakpoint hit without a read");
            write_only_a: assert property ( // [R4]
                hit[k] && bp_reg[k].acc == `BSM_ACC_WR
                && bp_reg[k].bus == `BSM_BUS_Y |-> ybus_i.wr)
                else $error("write breakpoint hit without a write");
            rw_any_a: assert property ( // [R5]
                bp_reg[k].acc == `BSM_ACC_RW && bp_reg[k].bus == `BSM_BUS_X
                && bp_reg[k].cond == `BSM_COND_ADDR && xbus_i.wr
                && xbus_i.addr == bp_reg[k].addr |-> hit[k])
                else $error("read or write breakpoint missed a write");
            data_eq_a: assert property ( // [R7]
                hit[k] && bp_reg[k].cond == `BSM_COND_EQ
                && bp_reg[k].bus == `BSM_BUS_X
                |-> xbus_i.data == bp_reg[k].data)
                else $error("equal condition hit on other data");
            data_ne_a: assert property ( // [R8]
                hit[k] && bp_reg[k].cond == `BSM_COND_NE
                && bp_reg[k].bus == `BSM_BUS_Y
                |-> ybus_i.data != bp_reg[k].data)
                else $error("not-equal condition hit on equal data");
            signed_lt_a: assert property ( // [R9]
                hit[k] && bp_reg[k].cond == `BSM_COND_LT
                && bp_reg[k].bus == `BSM_BUS_X
                |-> $signed(xbus_i.data) < $signed(bp_reg[k].data))
                else $error("less-than condition hit on larger data");
            signed_ge_a: assert property ( // [R10]
                hit[k] && bp_reg[k].cond == `BSM_COND_GE
                && bp_reg[k].bus == `BSM_BUS_Y
                |-> $signed(ybus_i.data) >= $signed(bp_reg[k].data))
                else $error("greater-equal condition hit on smaller data");
            trig_set_a: assert property ( // [R12]
                fire && hit[k] |=> bp_reg[k].trig)
                else $error("triggered flag not set by firing breakpoint");
        end
    endgenerate

    // ****************************************
    // Event counting and firing
    // ****************************************
    assign snoop_event = ena_reg & (|hit); // [R14] [R15]
    assign fire = snoop_event && event_down_count_reg == `BSM_RST_COUNT;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_down_count_reg <= `BSM_RST_COUNT;
        end else if (wr_take && !in_bp && reg_ofs == `BSM_OFS_COUNT) begin
            event_down_count_reg <=
                lane16(event_down_count_reg, wb_dat_i, wb_sel_i);
        end else if (snoop_event && !fire) begin
            event_down_count_reg <= event_down_count_reg - 16'h0001; // [R13]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            break_instr_address_reg <= `BSM_RST_BREAK_INSTR_ADDRESS;
        end else if (fire) begin
            break_instr_address_reg <= ibus_i.addr; // [R13]
        end
    end

    // Firing stops matching until software enables again
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ena_reg <= 1'b0;
        end else if (fire) begin
            ena_reg <= 1'b0; // [R14]
        end else if (wr_take && !in_bp && reg_ofs == `BSM_OFS_CTRL
                     && wb_sel_i[0]) begin
            ena_reg <= wb_dat_i[`BSM_ENA_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            break_reg <= 1'b0;
        end else begin
            break_reg <= fire;
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    // Only the bits that were returned are cleared, so a new event survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st_reg <= 1'b0;
        end else if (fire) begin
            irq_st_reg <= 1'b1; // [R13]
        end else if (rd_take && !in_bp && reg_ofs == `BSM_OFS_IRQ_ST) begin
            irq_st_reg <= irq_st_reg & ~dat_reg[`BSM_IRQ_BRK_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_reg <= `BSM_RST_MASK;
        end else if (wr_take && !in_bp && reg_ofs == `BSM_OFS_IRQ_MASK
                     && wb_sel_i[0]) begin
            irq_mask_reg <= wb_dat_i[`BSM_IRQ_BRK_BIT];
        end
    end

    assign snoop_enable_o = ena_reg;
    assign break_o = break_reg;
    assign irq_o = irq_st_reg & irq_mask_reg;

    // ****************************************
    // Checks
    // ****************************************
    sequence fire_s;
        snoop_event && event_down_count_reg == 16'h0000;
    endsequence

    sequence count_s;
        snoop_event && event_down_count_reg != 16'h0000 && !wr_take;
    endsequence

    count_dec_a: assert property ( // [R13]
        count_s |=> event_down_count_reg ==
            $past(event_down_count_reg) - 16'h0001)
        else $error("counter did not step down on event");
    fire_capture_a: assert property ( // [R13]
        fire_s |=> irq_st_reg && break_o
            && break_instr_address_reg == $past(ibus_i.addr))
        else $error("firing did not raise status or capture address");
    fire_disable_a: assert property ( // [R14]
        fire_s |=> !snoop_enable_o ##1 !break_o)
        else $error("enable not cleared after firing");
    enable_gate_a: assert property ( // [R14]
        !ena_reg |-> !snoop_event ##1 !break_o)
        else $error("event while snooper disabled");
    ack_once_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");

endmodule // bsm_top

// [tb/bsm_core_model.sv]
// Behavioural model of the core's instruction and data buses
module bsm_core_model (
    // Clock
    input wire logic clk_i,
    // Snooped buses
    output bsm_pkg::bsm_bus_t ibus_o,
    output bsm_pkg::bsm_bus_t xbus_o,
    output bsm_pkg::bsm_bus_t ybus_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ibus_o = '0;
        xbus_o = '0;
        ybus_o = '0;
    end

    // Idle bus: no strobe, lines flip so stale values never look valid
    function automatic bsm_pkg::bsm_bus_t idle(input bsm_pkg::bsm_bus_t b);
        return '{1'b0, 1'b0, ~b.addr, ~b.data};
    endfunction

    // One access for one cycle; rw is {rd, wr}; pc is the fetch address
    task automatic access(input logic [1:0] b, input logic [1:0] rw,
                          input logic [15:0] a, input logic [15:0] d,
                          input logic [15:0] pc);
        bsm_pkg::bsm_bus_t acc;
        acc = '{rw[1], rw[0], a, d};
        ibus_o <= (b == 2'h0) ? acc
            : bsm_pkg::bsm_bus_t'{1'b0, 1'b0, pc, ~ibus_o.data};
        xbus_o <= (b == 2'h1) ? acc : idle(xbus_o);
        ybus_o <= (b == 2'h2) ? acc : idle(ybus_o);
        @(posedge clk_i);
        ibus_o <= idle(ibus_o);
        xbus_o <= idle(xbus_o);
        ybus_o <= idle(ybus_o);
    endtask
endmodule // bsm_core_model

// [tb/bsm_top_test.sv]
// Self-checking testbench of the breakpoint snoop matcher
module bsm_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals
    // ****************************************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack;
    bsm_pkg::bsm_bus_t ibus;
    bsm_pkg::bsm_bus_t xbus;
    bsm_pkg::bsm_bus_t ybus;
    logic snoop_enable_o;
    logic break_o;
    logic irq_o;
    int n_mismatch = 0;
    int compares = 0;
    int n_break = 0;
    int nb;
    logic [7:0] bp = 8'h80;
    logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h80, 8'h44};

    bsm_top #(.NBP(8)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack),
        .ibus_i(ibus), .xbus_i(xbus), .ybus_i(ybus),
        .snoop_enable_o(snoop_enable_o), .break_o(break_o), .irq_o(irq_o)
    );

    bsm_core_model u_core (
        .clk_i(clk_i), .ibus_o(ibus), .xbus_o(xbus), .ybus_o(ybus)
    );

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (break_o === 1'b1) n_break++;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic end_sim;
        $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    // Classic single cycle; the answer latency is not assumed
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= 4'hf;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask

    // Cfg byte: trig, bus[1:0], acc[1:0], cond[2:0]; rw is {rd, wr}
    task automatic run_case(input logic [7:0] cfg, input logic [1:0] b,
                            input logic [1:0] rw, input logic [15:0] a,
                            input logic [15:0] d, input logic hit);
        int n0;
        wr(bp, {24'h0, cfg});
        wr(bp + 8'h04, 32'h0100);
        wr(bp + 8'h08, 32'h0010);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h1);
        n0 = n_break;
        u_core.access(b, rw, a, d, 16'h0c35);
        @(posedge clk_i);
        chk_bit(irq_o, hit);
        chk_bit(snoop_enable_o, !hit);
        rdc(bp, {24'h0, hit, cfg[6:0]});
        rdc(8'h0c, {31'h0, hit});
        if (hit) rdc(8'h08, {16'h0, (b == 2'h0) ? a : 16'h0c35});
        chk(32'(n_break - n0), {31'h0, hit});
        wr(8'h00, 32'h0);
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 7; i++) rdc(ofs[i], 32'h0);
        chk_bit(snoop_enable_o, 1'b0);
        chk_bit(irq_o, 1'b0);
        $display("test reset done");
        wr(8'h10, 32'h1);
        run_case(8'h29, 2'h1, 2'h2, 16'h0100, 16'h0010, 1'b1);
        run_case(8'h29, 2'h1, 2'h1, 16'h0100, 16'h0010, 1'b0);
        run_case(8'h31, 2'h1, 2'h1, 16'h0100, 16'h0010, 1'b1);
        run_case(8'h31, 2'h1, 2'h2, 16'h0100, 16'h0010, 1'b0);
        run_case(8'h51, 2'h2, 2'h1, 16'h0100, 16'h0010, 1'b1);
        run_case(8'h59, 2'h2, 2'h2, 16'h0100, 16'h0010, 1'b1);
        run_case(8'h59, 2'h2, 2'h1, 16'h0100, 16'h0010, 1'b1);
        run_case(8'h59, 2'h1, 2'h1, 16'h0100, 16'h0010, 1'b0);
        run_case(8'h21, 2'h1, 2'h2, 16'h0100, 16'h0010, 1'b0);
        run_case(8'h28, 2'h1, 2'h2, 16'h0100, 16'h0010, 1'b0);
        run_case(8'h39, 2'h1, 2'h1, 16'h0101, 16'h0010, 1'b0);
        run_case(8'h3a, 2'h1, 2'h1, 16'h0100, 16'h0010, 1'b1);
        run_case(8'h3a, 2'h1, 2'h1, 16'h0100, 16'h0011, 1'b0);
        run_case(8'h3b, 2'h2, 2'h2, 16'h0100, 16'h0011, 1'b0);
        run_case(8'h3b, 2'h1, 2'h2, 16'h0100, 16'h0011, 1'b1);
        run_case(8'h3b, 2'h1, 2'h2, 16'h0100, 16'h0010, 1'b0);
        run_case(8'h5b, 2'h2, 2'h2, 16'h0100, 16'h0011, 1'b1);
        run_case(8'h3c, 2'h1, 2'h1, 16'h0100, 16'hfff0, 1'b1);
        run_case(8'h3c, 2'h1, 2'h1, 16'h0100, 16'h0010, 1'b0);
        run_case(8'h3d, 2'h1, 2'h1, 16'h0100, 16'h0010, 1'b1);
        run_case(8'h3d, 2'h1, 2'h1, 16'h0100, 16'hfff0, 1'b0);
        run_case(8'h5d, 2'h2, 2'h1, 16'h0100, 16'h7fff, 1'b1);
        run_case(8'h09, 2'h0, 2'h2, 16'h0100, 16'h0010, 1'b1);
        run_case(8'h0a, 2'h0, 2'h2, 16'h0100, 16'h0010, 1'b0);
        $display("test match done");
        wr(8'h80, 32'h39);
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h1);
        nb = n_break;
        for (int i = 2; i > 0; i--) begin
            u_core.access(2'h1, 2'h1, 16'h0100, 16'h0, 16'h0a5a);
            rdc(8'h04, 32'(i - 1));
            chk_bit(snoop_enable_o, 1'b1);
        end
        u_core.access(2'h1, 2'h1, 16'h0100, 16'h0, 16'h0a5a);
        rdc(8'h08, 32'h0a5a);
        rdc(8'h04, 32'h0);
        chk_bit(snoop_enable_o, 1'b0);
        u_core.access(2'h1, 2'h1, 16'h0100, 16'h0, 16'h0a5a);
        rdc(8'h04, 32'h0);
        chk(32'(n_break - nb), 32'h1);
        $display("test counter done");
        wr(8'h10, 32'h0);
        chk_bit(irq_o, 1'b0);
        wr(8'h10, 32'h1);
        chk_bit(irq_o, 1'b1);
        rdc(8'h0c, 32'h1);
        chk_bit(irq_o, 1'b0);
        rdc(8'h0c, 32'h0);
        $display("test irq done");
        wr(8'h80, 32'h0);
        bp = 8'hf0;
        run_case(8'h29, 2'h1, 2'h2, 16'h0100, 16'h0010, 1'b1);
        $display("test last breakpoint done");
        end_sim;
    end

    // Whole run is under nine hundred cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        end_sim;
    end
endmodule // bsm_top_test
